// ===== hw/fine_gain_trim_regs.v
// Fine gain trim register bank with APB access and per-core gain selection.
`timescale 1ns/10ps
`default_nettype none
`include "fine_gain_map.vh"

// Summary of operation
// R1 - Core 1 uses its own 5-bit trim.
// R2 - Core 2 on input A uses input-A trim.
// R3 - Core 2 on input B uses input-B trim.
// R4 - Core 3 on input C uses input-C trim.
// R5 - Core 3 on input D uses input-D trim.
// R6 - Core 4 uses its own 5-bit trim.
// R7 - Core 5 uses its own 5-bit trim.
// R8 - Software keeps reserved bits 7:5 at zero.
// R9 - Reset loads factory fuse trims into fields.
// R10 - Writes affect later samples; reads return held.
module fine_gain_trim_regs #(
    parameter NREG = `FG_NUM_REGS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [8*NREG-1:0] fuse_defaults,
    input wire conv2_sel_input_b,
    input wire conv3_sel_input_d,
    output reg [4:0] gain_conv1_r,
    output reg [4:0] gain_conv2_r,
    output reg [4:0] gain_conv3_r,
    output reg [4:0] gain_conv4_r,
    output reg [4:0] gain_conv5_r
);

    // ==========================================================
    // Fuse load sequencing
    // ==========================================================
    // The fuse bus is sampled one clock after reset release, so reset
    // itself only ever drives constants into the flops.
    reg fuse_done_r;
    wire fuse_load;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fuse_done_r <= 1'b0;
        else
            fuse_done_r <= 1'b1;
    end

    assign fuse_load = !fuse_done_r; // [R9]

    // ==========================================================
    // APB decode
    // ==========================================================
    wire [11:0] idx;
    wire [11:0] rel;
    wire in_range;
    wire access;
    wire [8*NREG-1:0] regs_flat;

    assign idx = paddr[`FG_ADDR_W-1:`FG_ADDR_LSB];
    assign rel = idx - `FG_IDX_FIRST;
    assign in_range = (idx >= `FG_IDX_FIRST) && (rel < NREG) &&
        (paddr[`FG_ADDR_LSB-1:0] == 2'h0) && (paddr[31:`FG_ADDR_W] == 18'h00000);
    assign access = psel && penable;
    // Zero wait states; registers are ready while the fuse copy is in progress too.
    assign pready = 1'b1;
    assign pslverr = access && !in_range;

    // Only byte lane 0 carries the register, so pstrb[0] gates the write.
    // Reserved bits 7:5 are stored as written and read back. [R8]
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1)
        begin : cells
            fine_gain_cell #(
                .WIDTH(`FG_WIDTH)
            ) u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .fuse_load(fuse_load),
                .fuse_value(fuse_defaults[8*g+7:8*g]),
                .wr_en(access && pwrite && in_range && pstrb[0] && (rel == g)),
                .wr_data(pwdata[7:0]),
                .value_r(regs_flat[8*g+7:8*g])
            );
        end
    endgenerate

    // Read data comes straight from the held register, upper bits zero. [R10]
    reg [7:0] rd_byte;
    integer i;

    always @*
    begin
        rd_byte = 8'h00;
        for (i = 0; i < NREG; i = i + 1)
        begin
            if (in_range && (rel == i))
                rd_byte = regs_flat[8*i+:8];
        end
    end

    assign prdata = {24'h000000, rd_byte};

    // ==========================================================
    // Gain selection toward the converter cores
    // ==========================================================
    // Selection is registered so each core sees a clean value at sample time;
    // a write is visible to cores one clock after its APB access edge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_conv1_r <= 5'h00;
            gain_conv2_r <= 5'h00;
            gain_conv3_r <= 5'h00;
            gain_conv4_r <= 5'h00;
            gain_conv5_r <= 5'h00;
        end
        else
        begin
            gain_conv1_r <= regs_flat[8*0+`FG_FIELD_MSB:8*0]; // [R1]
            if (conv2_sel_input_b)
                gain_conv2_r <= regs_flat[8*2+`FG_FIELD_MSB:8*2]; // [R3]
            else
                gain_conv2_r <= regs_flat[8*1+`FG_FIELD_MSB:8*1]; // [R2]
            if (conv3_sel_input_d)
                gain_conv3_r <= regs_flat[8*4+`FG_FIELD_MSB:8*4]; // [R5]
            else
                gain_conv3_r <= regs_flat[8*3+`FG_FIELD_MSB:8*3]; // [R4]
            gain_conv4_r <= regs_flat[8*5+`FG_FIELD_MSB:8*5]; // [R6]
            gain_conv5_r <= regs_flat[8*6+`FG_FIELD_MSB:8*6]; // [R7]
        end
    end

endmodule // fine_gain_trim_regs

`default_nettype wire

// ===== hw/fine_gain_map.vh
// Register offsets, field layout and reset values of the fine gain trim bank.
`ifndef FINE_GAIN_MAP_VH
`define FINE_GAIN_MAP_VH

// Printed offsets are register indices, so the byte address is four times the index.
`define FG_IDX_CONV1 12'h361
`define FG_IDX_CONV2_INPUT_A 12'h362
`define FG_IDX_CONV2_INPUT_B 12'h363
`define FG_IDX_CONV3_INPUT_C 12'h364
`define FG_IDX_CONV3_INPUT_D 12'h365
`define FG_IDX_CONV4 12'h366
`define FG_IDX_CONV5 12'h367
`define FG_IDX_FIRST 12'h361
`define FG_NUM_REGS 7
`define FG_ADDR_LSB 2
`define FG_ADDR_W 14
`define FG_FIELD_MSB 4
`define FG_FIELD_LSB 0
`define FG_RSVD_MSB 7
`define FG_RSVD_LSB 5
`define FG_REG_RESET 8'h00
`define FG_WIDTH 8

`endif

// ===== hw/fine_gain_cell.v
// One fine gain trim register with fuse load and APB write.
`timescale 1ns/10ps
`default_nettype none
`include "fine_gain_map.vh"

module fine_gain_cell #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire fuse_load,
    input wire [WIDTH-1:0] fuse_value,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    output reg [WIDTH-1:0] value_r
);

    // Asynchronous reset takes the printed zero; the fuse value follows one clock later.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_r <= `FG_REG_RESET;
        else if (fuse_load)
            value_r <= fuse_value; // [R9]
        else if (wr_en)
            value_r <= wr_data; // [R10]
    end

endmodule // fine_gain_cell

`default_nettype wire

// ===== bench/fine_gain_trim_regs_assertions.sv
// Port-level checker for the fine gain trim bank.
`timescale 1ns/10ps
`default_nettype none
module fg_chk #(
    parameter NREG = 7
) (
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [31:0] paddr, pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [8*NREG-1:0] fuse_defaults,
    input wire logic conv2_sel_input_b, conv3_sel_input_d,
    input wire logic [4:0] gain_conv1_r, gain_conv2_r, gain_conv3_r,
    input wire logic [4:0] gain_conv4_r, gain_conv5_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The select must hold for two edges, since the trim reaches the core one clock late.
    property wg(logic [31:0] a, logic s, logic [4:0] g);
        psel && penable && pwrite && pstrb[0] && paddr == a && s ##1 s
            |=> g == $past(pwdata[4:0], 2);
    endproperty
    chk_conv1_gain: assert property (wg(32'hD84, 1'b1, gain_conv1_r)) else $error("conv1");
    chk_conv2a_sel: assert property (wg(32'hD88, !conv2_sel_input_b, gain_conv2_r))
        else $error("conv2 a");
    chk_conv2b_sel: assert property (wg(32'hD8C, conv2_sel_input_b, gain_conv2_r))
        else $error("conv2 b");
    chk_conv3c_sel: assert property (wg(32'hD90, !conv3_sel_input_d, gain_conv3_r))
        else $error("conv3 c");
    chk_conv3d_sel: assert property (wg(32'hD94, conv3_sel_input_d, gain_conv3_r))
        else $error("conv3 d");
    chk_conv4_gain: assert property (wg(32'hD98, 1'b1, gain_conv4_r)) else $error("conv4");
    chk_conv5_gain: assert property (wg(32'hD9C, 1'b1, gain_conv5_r)) else $error("conv5");
    chk_fuse_load: assert property ($rose(presetn) |=> ##1 gain_conv4_r == fuse_defaults[44:40])
        else $error("fuse");
    chk_ready_zero: assert property (psel && penable |-> pready) else $error("ready");
    cover property (psel && penable && pwrite);
    cover property (psel && penable && !pstrb[0]);
    cover property ($rose(presetn));
endmodule // fg_chk
bind fine_gain_trim_regs fg_chk #(.NREG(NREG)) i_fg_chk (.*);
`default_nettype wire

// ===== bench/fine_gain_trim_regs_test.sv
// Self-checking bench for the fine gain trim bank.
`timescale 1ns/10ps
`default_nettype none
module fine_gain_trim_regs_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [55:0] fuse_defaults = 0;
    logic conv2_sel_input_b = 0, conv3_sel_input_d = 0;
    logic [4:0] gain_conv1_r, gain_conv2_r, gain_conv3_r, gain_conv4_r, gain_conv5_r;
    logic [32:0] exp_q[$];
    logic [7:0] v;
    int error_cnt = 0, samples_checked = 0;
    fine_gain_trim_regs i_fine_gain_trim_regs (.*);
    initial forever #10 pclk = ~pclk;
    initial
    begin
        #20000;
        error_cnt++;
        end_sim;
    end
    // ==========
    // Bus tasks
    task end_sim;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [32:0] e, input logic [32:0] a);
        samples_checked++;
        if (a !== e) $display("Error %0t exp %h got %h", $time, e, a);
        if (a !== e) error_cnt++;
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask
    // Reads are compared at the access edge, where the answer is sampled.
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk(exp_q.pop_front(), {pslverr, prdata});
    // ==========
    // Scenarios
    initial
    begin
        void'($urandom(32'hF063));
        fuse_defaults <= 56'({$urandom, $urandom});
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 7; i++) apb(0, 32'hD84 + 4 * i, 0, {25'h0, fuse_defaults[8*i+:8]});
        for (int i = 0; i < 7; i++)
        begin
            v = 8'($urandom) & 8'h1F;
            conv2_sel_input_b <= (i == 2);
            conv3_sel_input_d <= (i == 4);
            apb(1, 32'hD84 + 4 * i, v, 0);
            apb(0, 32'hD84 + 4 * i, 0, {25'h0, v});
        end
        pstrb <= 4'h0;
        apb(1, 32'hD9C, v ^ 8'h1F, 0);
        pstrb <= 4'hF;
        apb(0, 32'hD9C, 0, {25'h0, v});
        apb(0, 32'hDA0, 0, {1'b1, 32'h0});
        repeat (3) @(posedge pclk);
        end_sim;
    end
endmodule // fine_gain_trim_regs_test
`default_nettype wire
